/* rxi_pkg.sv */
// package: register map, fields and timing for the receive integration / ext ram block
package rxi_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // printed offsets are register indexes; byte address is four times the index
  localparam logic [11:0] IDX_INTEG_BASE = 12'h219;
  localparam logic [11:0] IDX_INTEG_LAST = 12'h21C;
  localparam logic [11:0] IDX_XRAM_CTRL = 12'h280;
  localparam logic [11:0] IDX_XRAM_ADDR = 12'h27F;
  localparam logic [11:0] IDX_XRAM_DATA = 12'h284;
  localparam int NUM_INTEG = 4;
  localparam logic [15:0] INTEG_RST = 16'h0C0C;
  localparam int INTEG_LO_MSB = 3;
  localparam int INTEG_HI_LSB = 8;
  localparam int INTEG_HI_MSB = 11;
  localparam logic [3:0] CODE_RESERVED = 4'hF;
  localparam int PERIOD_BASE_LOG2 = 8;
  localparam int CTL_READY = 7;
  localparam int CTL_TOGGLE = 6;
  localparam int CTL_DIR = 5;
  localparam int CTL_RSVD = 2;
  localparam int CTL_OP_MSB = 1;
  localparam logic [1:0] OP_INIT = 2'h0;
  localparam logic [1:0] OP_XFER = 2'h1;
  localparam int XRAM_AW = 8;
  localparam int XRAM_DW = 8;
  localparam int XRAM_DEPTH = 256;
  localparam int XRAM_AW_CNT = 9;
  typedef enum {RXI_IDLE, RXI_INIT, RXI_WR, RXI_RD, RXI_RD_WAIT, RXI_DONE} rxi_state_t;
endpackage : rxi_pkg

/* rxi_regs.sv */
// register bank: integration periods per group and external ram transfer control
`timescale 1ns/100ps
`default_nettype none
module rxi_regs
  import rxi_pkg::*;
#(
  parameter int INIT_WORDS = XRAM_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W+1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic [2*NUM_INTEG-1:0] period_tick_o,
  output logic [2*NUM_INTEG-1:0] code_reserved_o
);

  // cycle count of an integration code: 2^(8+code), capped at code 14
  function automatic logic [22:0] period_of(input logic [3:0] code);
    logic [4:0] sh;
    sh = 5'(PERIOD_BASE_LOG2) + 5'(code);
    if (code == CODE_RESERVED)
      sh = 5'd22;
    period_of = 23'(1) << sh;
  endfunction : period_of

  logic [15:0] integ_r [NUM_INTEG];
  logic [7:0] xaddr_r;
  logic [7:0] xdata_r;
  logic dir_r, rsvd_r, ready_r, toggle_r, ready_d_r;
  logic [1:0] op_r;
  logic [XRAM_DW-1:0] xram [XRAM_DEPTH];
  logic [XRAM_DW-1:0] xram_q_r;
  logic [XRAM_AW_CNT-1:0] init_cnt_r;
  rxi_state_t state_r;
  logic ack_r;

  wire logic req = wb_cyc_i && wb_stb_i && !ack_r;
  wire logic [ADDR_W-1:0] idx = wb_adr_i[ADDR_W+1:2];
  wire logic wr_lo = req && wb_we_i && wb_sel_i[0];
  wire logic wr_hi = req && wb_we_i && wb_sel_i[1];
  wire logic hit_integ = (idx >= IDX_INTEG_BASE) && (idx <= IDX_INTEG_LAST);
  wire logic hit_ctrl = (idx == IDX_XRAM_CTRL);
  wire logic hit_addr = (idx == IDX_XRAM_ADDR);
  wire logic hit_data = (idx == IDX_XRAM_DATA);
  wire logic mapped = hit_integ || hit_ctrl || hit_addr || hit_data;
  wire logic [1:0] integ_sel = 2'(idx - IDX_INTEG_BASE);
  wire logic ctrl_wr = wr_lo && hit_ctrl;

  // single-cycle wishbone answer: ack or err one edge after the request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      ack_r <= req;
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
    end
  end

  // integration registers; reserved nibble 7:4 and 15:12 never stored
  genvar g;
  generate
    for (g = 0; g < NUM_INTEG; g++) begin : g_integ
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          integ_r[g] <= INTEG_RST;
        end else if (hit_integ && integ_sel == 2'(g)) begin
          if (wr_lo)
            integ_r[g][INTEG_LO_MSB:0] <= wb_dat_i[INTEG_LO_MSB:0];
          if (wr_hi)
            integ_r[g][INTEG_HI_MSB:INTEG_HI_LSB] <= wb_dat_i[INTEG_HI_MSB:INTEG_HI_LSB];
        end
      end
    end
  endgenerate

  // per-group integration timers; the period of each group comes from its code
  logic [22:0] tmr_r [2*NUM_INTEG];
  logic [3:0] grp_code [2*NUM_INTEG];
  generate
    for (g = 0; g < 2*NUM_INTEG; g++) begin : g_tmr
      if (g < NUM_INTEG) begin : g_lo
        assign grp_code[g] = integ_r[g][INTEG_LO_MSB:0];
      end else begin : g_hi
        assign grp_code[g] = integ_r[g-NUM_INTEG][INTEG_HI_MSB:INTEG_HI_LSB];
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          tmr_r[g] <= '0;
          period_tick_o[g] <= 1'b0;
          code_reserved_o[g] <= 1'b0;
        end else begin
          code_reserved_o[g] <= (grp_code[g] == CODE_RESERVED);
          if (tmr_r[g] >= period_of(grp_code[g]) - 23'd1) begin
            tmr_r[g] <= '0;
            period_tick_o[g] <= 1'b1;
          end else begin
            tmr_r[g] <= tmr_r[g] + 23'd1;
            period_tick_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // address and data registers used by transfers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xaddr_r <= '0;
      xdata_r <= '0;
    end else begin
      if (wr_lo && hit_addr)
        xaddr_r <= wb_dat_i[7:0];
      if (state_r == RXI_RD_WAIT)
        xdata_r <= xram_q_r;
      else if (wr_lo && hit_data)
        xdata_r <= wb_dat_i[7:0];
    end
  end

  // control fields; writes while busy are still stored and restart nothing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= 1'b0;
      rsvd_r <= 1'b0;
      op_r <= 2'h0;
    end else if (ctrl_wr) begin
      dir_r <= wb_dat_i[CTL_DIR];
      rsvd_r <= wb_dat_i[CTL_RSVD];
      op_r <= wb_dat_i[CTL_OP_MSB:0];
    end
  end

  // transfer sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RXI_IDLE;
      init_cnt_r <= '0;
    end else begin
      case (state_r)
        RXI_IDLE: begin
          if (ctrl_wr) begin
            init_cnt_r <= '0;
            if (wb_dat_i[CTL_OP_MSB])
              state_r <= RXI_DONE;
            else if (wb_dat_i[0] == OP_INIT[0])
              state_r <= RXI_INIT;
            else if (wb_dat_i[CTL_DIR])
              state_r <= RXI_RD;
            else
              state_r <= RXI_WR;
          end
        end
        RXI_INIT: begin
          init_cnt_r <= init_cnt_r + 9'd1;
          if (init_cnt_r == 9'(INIT_WORDS - 1))
            state_r <= RXI_DONE;
        end
        RXI_WR: state_r <= RXI_DONE;
        RXI_RD: state_r <= RXI_RD_WAIT;
        RXI_RD_WAIT: state_r <= RXI_DONE;
        RXI_DONE: state_r <= RXI_IDLE;
        default: state_r <= RXI_IDLE;
      endcase
    end
  end

  // external ram array
  always_ff @(posedge mclk) begin
    if (state_r == RXI_INIT)
      xram[init_cnt_r[XRAM_AW-1:0]] <= '0;
    else if (state_r == RXI_WR)
      xram[xaddr_r] <= xdata_r;
    xram_q_r <= xram[xaddr_r];
  end

  // ready flag: cleared by the control write, set when the sequencer finishes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= 1'b1;
      ready_d_r <= 1'b1;
      toggle_r <= 1'b0;
    end else begin
      // finish beats a same-cycle control write, which starts nothing, so ready cannot stick low
      if (state_r == RXI_DONE)
        ready_r <= 1'b1;
      else if (ctrl_wr)
        ready_r <= 1'b0;
      ready_d_r <= ready_r;
      if (ready_r && !ready_d_r)
        toggle_r <= ~toggle_r;
    end
  end

  // read mux; unused bits return zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= '0;
      if (hit_integ)
        wb_dat_o <= {16'h0000, integ_r[integ_sel] & 16'h0F0F};
      else if (hit_ctrl)
        wb_dat_o <= {24'h0, ready_r, toggle_r, dir_r, 2'b00, rsvd_r, op_r};
      else if (hit_addr)
        wb_dat_o <= {24'h0, xaddr_r};
      else if (hit_data)
        wb_dat_o <= {24'h0, xdata_r};
    end
  end

  property p_ready_clear;
    @(posedge mclk) disable iff (!rst_n) (ctrl_wr && state_r != RXI_DONE) |=> !ready_r;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

  sequence s_xfer_cmd;
    ctrl_wr && !wb_dat_i[CTL_OP_MSB] && wb_dat_i[0] && state_r == RXI_IDLE;
  endsequence
  property p_xfer_done;
    @(posedge mclk) disable iff (!rst_n) s_xfer_cmd |-> ##[3:4] ready_r;
  endproperty
  a_xfer_done: assert property (p_xfer_done) else $error("transfer did not finish");

  property p_toggle;
    @(posedge mclk) disable iff (!rst_n) $rose(ready_d_r) |-> toggle_r != $past(toggle_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed ready edge");

  property p_toggle_hold;
    @(posedge mclk) disable iff (!rst_n) !(ready_r && !ready_d_r) |=> $stable(toggle_r);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved");

  property p_idle_op;
    @(posedge mclk) disable iff (!rst_n)
      (ctrl_wr && wb_dat_i[CTL_OP_MSB] && state_r == RXI_IDLE) |=> state_r == RXI_DONE;
  endproperty
  a_idle_op: assert property (p_idle_op) else $error("idle op touched ram");

  property p_dir_rd;
    @(posedge mclk) disable iff (!rst_n) (s_xfer_cmd and wb_dat_i[CTL_DIR]) |=> state_r == RXI_RD;
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("wrong direction");

  property p_integ_rd;
    @(posedge mclk) disable iff (!rst_n)
      (req && !wb_we_i && hit_integ) |=> wb_dat_o[15:12] == 4'h0 && wb_dat_o[7:4] == 4'h0;
  endproperty
  a_integ_rd: assert property (p_integ_rd) else $error("integration reserved bits nonzero");

  property p_ctrl_rd;
    @(posedge mclk) disable iff (!rst_n)
      (req && !wb_we_i && hit_ctrl) |=> wb_dat_o[15:8] == 8'h0 && wb_dat_o[4:3] == 2'b00;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control unused bits nonzero");

  property p_tick_period;
    @(posedge mclk) disable iff (!rst_n)
      (period_tick_o[0] && grp_code[0] == 4'h0 && $stable(grp_code[0])) |-> ##256 period_tick_o[0];
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("period of code 0 wrong");

  property p_ack_once;
    @(posedge mclk) disable iff (!rst_n) (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o);
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("answer held two cycles");

  property p_ready_set_wins;
    @(posedge mclk) disable iff (!rst_n) (ctrl_wr && state_r == RXI_DONE) |=> ready_r;
  endproperty
  a_ready_set_wins: assert property (p_ready_set_wins) else $error("finish lost to write");

  property p_done_ready;
    @(posedge mclk) disable iff (!rst_n) state_r == RXI_DONE |=> ready_r;
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("ready not set at finish");

  sequence s_init_cmd;
    ctrl_wr && !wb_dat_i[CTL_OP_MSB] && !wb_dat_i[0] && state_r == RXI_IDLE;
  endsequence
  property p_init_start;
    @(posedge mclk) disable iff (!rst_n) s_init_cmd |=> state_r == RXI_INIT && init_cnt_r == '0;
  endproperty
  a_init_start: assert property (p_init_start) else $error("init not started");

  property p_init_end;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == RXI_INIT && init_cnt_r == 9'(INIT_WORDS - 1)) |=> state_r == RXI_DONE;
  endproperty
  a_init_end: assert property (p_init_end) else $error("init did not end");

  property p_dir_wr;
    @(posedge mclk) disable iff (!rst_n) (s_xfer_cmd and !wb_dat_i[CTL_DIR]) |=> state_r == RXI_WR;
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("wrong direction for store");

  property p_wr_ram;
    @(posedge mclk) disable iff (!rst_n)
      state_r == RXI_WR |=> xram[$past(xaddr_r)] == $past(xdata_r);
  endproperty
  a_wr_ram: assert property (p_wr_ram) else $error("ram word not stored");

  property p_rd_load;
    @(posedge mclk) disable iff (!rst_n) state_r == RXI_RD_WAIT |=> xdata_r == $past(xram_q_r);
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("data register not loaded");

  property p_ctrl_fields;
    @(posedge mclk) disable iff (!rst_n)
      ctrl_wr |=> dir_r == $past(wb_dat_i[CTL_DIR]) && op_r == $past(wb_dat_i[CTL_OP_MSB:0]);
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields) else $error("control fields not stored");

  property p_integ_lo;
    @(posedge mclk) disable iff (!rst_n)
      (wr_lo && hit_integ && integ_sel == 2'h0)
      |=> grp_code[0] == $past(wb_dat_i[INTEG_LO_MSB:0]);
  endproperty
  a_integ_lo: assert property (p_integ_lo) else $error("low group code not stored");

  property p_integ_hi;
    @(posedge mclk) disable iff (!rst_n)
      (wr_hi && hit_integ && integ_sel == 2'h0)
      |=> grp_code[NUM_INTEG] == $past(wb_dat_i[INTEG_HI_MSB:INTEG_HI_LSB]);
  endproperty
  a_integ_hi: assert property (p_integ_hi) else $error("high group code not stored");

  property p_tick_pulse;
    @(posedge mclk) disable iff (!rst_n) period_tick_o[0] |=> !period_tick_o[0];
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("period tick held");

endmodule : rxi_regs
`default_nettype wire

/* rxi_wbm.sv */
// partner model: classic wishbone host issuing single register cycles
`timescale 1ns/100ps
`default_nettype none
module rxi_wbm
  import rxi_pkg::*;
(
  input wire logic mclk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [ADDR_W+1:0] adr,
  output logic [3:0] sel,
  output logic [DATA_W-1:0] dat,
  input wire logic [DATA_W-1:0] dat_i,
  input wire logic ack,
  input wire logic err
);
  int tmo = 0;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    dat = '0;
  end
  // request held until ack or err is sampled high, released at that edge
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic e);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h3;
    dat <= wd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (ack !== 1'b1 && err !== 1'b1) tmo++;
    rd = dat_i;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // a released bus shows the inverse of the last address and data, with sel cleared
    sel <= 4'h0;
    adr <= ~adr;
    dat <= ~dat;
  endtask : xfer
endmodule : rxi_wbm
`default_nettype wire

/* rxi_regs_tb.sv */
// self-checking bench for the integration and external ram control registers
`timescale 1ns/100ps
`default_nettype none
module rxi_regs_tb;
  import rxi_pkg::*;
  logic mclk, rst_n, cyc, stb, we, ack, err, e;
  logic [ADDR_W+1:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, r, v;
  logic [7:0] tick, rsv;
  logic [3:0] lo[4], hi[4];
  logic [7:0] a, d;
  logic tog = 1'b0;
  logic [31:0] seed = 32'hA5BFF2CF;
  int errors = 0;
  int comparisons = 0;
  int n;
  rxi_regs #(.INIT_WORDS(4)) rxi_regs_inst (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .wb_err_o(err), .period_tick_o(tick),
    .code_reserved_o(rsv));
  rxi_wbm rxi_wbm_inst (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(dw), .dat_i(dr), .ack(ack), .err(err));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    errors += rxi_wbm_inst.tmo;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [11:0] i, input logic [31:0] x);
    logic [31:0] t;
    rxi_wbm_inst.xfer(1'b1, i, x, t, e);
    if (rxi_wbm_inst.tmo != 0) finish_test();
  endtask : wr
  task automatic rd(input logic [11:0] i, output logic [31:0] x);
    rxi_wbm_inst.xfer(1'b0, i, 32'h0, x, e);
    if (rxi_wbm_inst.tmo != 0) finish_test();
  endtask : rd
  // interval between two ticks of one group, sampled away from the launching edge
  task automatic period(input int g, input int exp);
    int k;
    k = 0;
    do @(negedge mclk); while (tick[g] !== 1'b1 && ++k < 3000);
    if (tick[g] !== 1'b1) begin
      errors++;
      finish_test();
    end
    k = 0;
    do @(negedge mclk); while (tick[g] !== 1'b1 && ++k < 3000);
    if (tick[g] !== 1'b1) begin
      errors++;
      finish_test();
    end
    check(k + 1, exp);
  endtask : period
  // issue a command, wait for ready, then check the whole control register image
  task automatic cmd(input logic [31:0] x, input logic early);
    wr(IDX_XRAM_CTRL, x);
    rd(IDX_XRAM_CTRL, r);
    if (early) check(r[7], 1'b0);
    n = 0;
    while (r[7] !== 1'b1 && n < 50) begin
      rd(IDX_XRAM_CTRL, r);
      n++;
    end
    if (n >= 50) begin
      errors++;
      finish_test();
    end
    tog = ~tog;
    rd(IDX_XRAM_CTRL, r);
    check(r, {24'h0, 1'b1, tog, x[5], 2'b00, x[2:0]});
  endtask : cmd
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(IDX_INTEG_BASE + 12'(i), r);
      check(r, {16'h0, INTEG_RST});
    end
    rd(IDX_XRAM_CTRL, r);
    check(r, 32'h80);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      lo[i] = v[3:0] % 4'hF;
      hi[i] = v[11:8] % 4'hF;
      wr(IDX_INTEG_BASE + 12'(i), {16'h0, v[15:12], hi[i], 4'h0, lo[i]});
    end
    for (int i = 0; i < 4; i++) begin
      rd(IDX_INTEG_BASE + 12'(i), r);
      check(r, {20'h0, hi[i], 4'h0, lo[i]});
    end
    rxi_wbm_inst.xfer(1'b0, IDX_INTEG_BASE - 12'h1, 32'h0, r, e);
    check({r[30:0], e}, 32'h1);
    check({24'h0, rsv}, 32'h0);
    wr(IDX_INTEG_BASE + 12'h1, 32'h0B09);
    rd(IDX_INTEG_BASE + 12'h1, r);
    check(r, 32'h0B09);
    $display("test integration registers done");
    wr(IDX_INTEG_BASE, 32'h0100);
    period(0, 256);
    period(4, 512);
    $display("test integration periods done");
    v = rnd();
    a = v[7:0];
    d = v[15:8];
    wr(IDX_XRAM_ADDR, {24'h0, a});
    cmd(32'h00, 1'b1);
    wr(IDX_XRAM_DATA, {24'h0, d});
    cmd(32'h01, 1'b0);
    wr(IDX_XRAM_DATA, {24'h0, ~d});
    cmd(32'h21, 1'b0);
    rd(IDX_XRAM_DATA, r);
    check(r, {24'h0, d});
    wr(IDX_XRAM_DATA, {24'h0, ~d});
    cmd(32'h22, 1'b0);
    cmd(32'h23, 1'b0);
    rd(IDX_XRAM_DATA, r);
    check(r, {24'h0, ~d});
    $display("test external ram transfers done");
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    tog = 1'b0;
    rd(IDX_INTEG_BASE, r);
    check(r, {16'h0, INTEG_RST});
    rd(IDX_XRAM_CTRL, r);
    check(r, 32'h80);
    $display("test second reset done");
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    finish_test();
  end
endmodule : rxi_regs_tb
`default_nettype wire
